// File: hw/psic_pkg.sv
// psic_pkg: constants and types of the status summary and interrupt control
// How it works
// - summary bit 5 mirrors jabber, only in 10 Mb/s, never cleared by reads
// - summary bit 4 is 1 once auto-negotiation has finished
// - summary bit 3 is 1 while loopback is enabled
// - summary bit 2 is resolved duplex: 1 full, 0 half
// - summary bit 0 mirrors link up, not cleared by reading the summary
// - control bits 15 to 4 ignore writes and read as zero
// - control bit 3 remaps event bits 11 and 12 for time interrupt
// - control bit 2 holds summary bit 7 and the pin interrupt while set; system status bit 0 latches only its rise
// - control bit 1 gates all event interrupts
// - control bit 0 makes shared pin interrupt output, else power-down input
// - events: quality, energy, link, speed, duplex, negotiation done, counter half
// - event bits latch even when disabled, clear when event register is read
// - summary bit 7 shows an interrupt pending, cleared by reading events
////////////////////////////////////////////////////////////////////////////////
package psic_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_LSS = 8'h10;
   localparam logic [7:0] IDX_ICTL = 8'h11;
   localparam logic [7:0] IDX_ESE = 8'h12;
   localparam logic [7:0] IDX_IST = 8'h13;
   localparam logic [7:0] IDX_IMSK = 8'h14;

   // summary field positions
   localparam int LSS_LINK = 0;
   localparam int LSS_SPD10 = 1;
   localparam int LSS_DUP = 2;
   localparam int LSS_LOOP = 3;
   localparam int LSS_AN = 4;
   localparam int LSS_JAB = 5;
   localparam int LSS_PEND = 7;

   // event bits, counted from event register bit 8
   localparam int EV_CTR = 1;
   localparam int EV_AN = 2;
   localparam int EV_DUP_TIME = 3;
   localparam int EV_SPD = 4;
   localparam int EV_LINK = 5;
   localparam int EV_ED = 6;
   localparam int EV_LQ = 7;
   localparam int ESE_ST_LSB = 8;

   // system interrupt status bits
   localparam int IST_PIN = 0;
   localparam int IST_PD = 1;

   // reset values
   localparam logic [3:0] ICTL_RST = 4'h0;
   localparam logic [7:0] ESE_EN_RST = 8'h00;
   localparam logic [7:0] ESE_ST_RST = 8'h00;
   localparam logic [1:0] IST_RST = 2'h0;
   localparam logic [1:0] IMSK_RST = 2'h0;

   typedef struct packed {
      logic jabber;
      logic an_done;
      logic loopback;
      logic full_dup;
      logic speed10;
      logic link;
   } psic_line_t;

   typedef struct packed {
      logic lq;
      logic ed;
      logic ctr_half;
      logic time_irq;
   } psic_evt_t;

   typedef struct packed {
      logic time_irq_remap;
      logic test_irq_force;
      logic global_irq_gate;
      logic pin_irq_out;
   } psic_ctl_t;

   typedef enum logic {PSIC_IDLE, PSIC_DONE} psic_apb_st_t;

   function automatic logic [7:0] byte_addr(input logic [7:0] idx);
      return {idx[5:0], 2'b00};
   endfunction

endpackage

// File: hw/psic_change_det.sv
// psic_change_det: one-cycle pulses on any change of four status levels
`timescale 1ns/100ps
`default_nettype none
module psic_change_det (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] level,
   output logic [3:0] change
);
   logic [3:0] prev;
   logic primed;

   // no pulse on the first cycle after reset: prev is not yet real
   assign change = primed ? (level ^ prev) : 4'h0;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prev <= 4'h0;
         primed <= 1'b0;
      end else begin
         prev <= level;
         primed <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: hw/psic_top.sv
// psic_top: status summary, interrupt control and event latches on APB
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module psic_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire psic_pkg::psic_line_t line_status,
   input wire psic_pkg::psic_evt_t events,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe,
   output logic powerdown_req,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   psic_pkg::psic_apb_st_t state;
   psic_pkg::psic_apb_st_t next_state;
   psic_pkg::psic_ctl_t ctl;
   logic [7:0] ev_en;
   logic [7:0] ev_st;
   logic [1:0] ist;
   logic [1:0] imsk;
   logic pend_q;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   wire setup = psel & ~penable;
   wire done = psel & penable & (state == psic_pkg::PSIC_DONE);
   wire sel_lss = paddr == psic_pkg::byte_addr(psic_pkg::IDX_LSS);
   wire sel_ictl = paddr == psic_pkg::byte_addr(psic_pkg::IDX_ICTL);
   wire sel_ese = paddr == psic_pkg::byte_addr(psic_pkg::IDX_ESE);
   wire sel_ist = paddr == psic_pkg::byte_addr(psic_pkg::IDX_IST);
   wire sel_imsk = paddr == psic_pkg::byte_addr(psic_pkg::IDX_IMSK);
   wire hit = sel_lss | sel_ictl | sel_ese | sel_ist | sel_imsk;
   // only lane 0 carries writable bits
   wire wr = done & pwrite & pstrb[0] & ~pslverr;
   wire rd_ese = done & ~pwrite & sel_ese;

   always_comb begin
      next_state = state;
      case (state)
         psic_pkg::PSIC_IDLE: begin
            if (setup) begin
               next_state = psic_pkg::PSIC_DONE;
            end
         end
         psic_pkg::PSIC_DONE: begin
            next_state = psic_pkg::PSIC_IDLE;
         end
         default: begin
            next_state = psic_pkg::PSIC_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // status summary

   wire [3:0] chg;
   wire [3:0] chg_lvl = {line_status.an_done, line_status.link,
      line_status.speed10, line_status.full_dup};

   psic_change_det u_chg (
      .sys_clk(sys_clk),
      .rst(rst),
      .level(chg_lvl),
      .change(chg)
   );

   wire an_rise = chg[3] & line_status.an_done;
   wire link_chg = chg[2];
   wire spd_chg = chg[1];
   wire dup_chg = chg[0];

   // jabber is meaningless at 100 Mb/s, so it is hidden there
   wire jab_bit = line_status.jabber & line_status.speed10;
   // live levels except bit 7, which follows the latched events; reads of the summary never clear them
   // duplex and speed are shown raw; the host qualifies them
   wire pending = (ctl.global_irq_gate & |(ev_st & ev_en))
      | ctl.test_irq_force;

   logic [15:0] lss_word;
   always_comb begin
      lss_word = 16'h0000;
      lss_word[psic_pkg::LSS_JAB] = jab_bit;
      lss_word[psic_pkg::LSS_AN] = line_status.an_done;
      lss_word[psic_pkg::LSS_LOOP] = line_status.loopback;
      lss_word[psic_pkg::LSS_DUP] = line_status.full_dup;
      lss_word[psic_pkg::LSS_SPD10] = line_status.speed10;
      lss_word[psic_pkg::LSS_LINK] = line_status.link;
      lss_word[psic_pkg::LSS_PEND] = pending;
   end

   ////////////////////////////////////////////////////////////////////////////
   // event latches

   logic [7:0] ev_set;
   always_comb begin
      ev_set = 8'h00;
      ev_set[psic_pkg::EV_LQ] = events.lq;
      ev_set[psic_pkg::EV_ED] = events.ed;
      ev_set[psic_pkg::EV_LINK] = link_chg;
      ev_set[psic_pkg::EV_AN] = an_rise;
      ev_set[psic_pkg::EV_CTR] = events.ctr_half;
      // remap picks where speed, duplex and time events land
      ev_set[psic_pkg::EV_SPD] = ctl.time_irq_remap ?
         (spd_chg | dup_chg) : spd_chg;
      ev_set[psic_pkg::EV_DUP_TIME] = ctl.time_irq_remap ?
         events.time_irq : dup_chg;
   end

   // clear only what the read returned; a new event in that cycle wins
   wire [7:0] ev_clr = rd_ese ? prdata[psic_pkg::ESE_ST_LSB +: 8] : 8'h00;
   wire [7:0] next_ev_st = (ev_st & ~ev_clr) | ev_set;

   ////////////////////////////////////////////////////////////////////////////
   // shared pin and system interrupt

   wire next_pd = ~ctl.pin_irq_out & ~pin_in;
   wire [1:0] ist_set = {next_pd & ~powerdown_req, pending & ~pend_q};
   wire [1:0] ist_clr = (wr & sel_ist) ? pwdata[1:0] : 2'h0;
   wire [1:0] next_ist = (ist & ~ist_clr) | ist_set;

   ////////////////////////////////////////////////////////////////////////////
   // read data

   wire [15:0] ictl_word = {12'h000, ctl};
   wire [15:0] ese_word = {ev_st, ev_en};
   wire [15:0] rd_word =
      sel_lss ? lss_word :
      sel_ictl ? ictl_word :
      sel_ese ? ese_word :
      sel_ist ? {14'h0000, ist} :
      sel_imsk ? {14'h0000, imsk} : 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state <= psic_pkg::PSIC_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         state <= next_state;
         pready <= next_state == psic_pkg::PSIC_DONE;
         if (setup && state == psic_pkg::PSIC_IDLE) begin
            pslverr <= ~hit;
            prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctl <= psic_pkg::ICTL_RST;
         ev_en <= psic_pkg::ESE_EN_RST;
         imsk <= psic_pkg::IMSK_RST;
      end else if (wr) begin
         if (sel_ictl) begin
            ctl <= pwdata[3:0];
         end
         if (sel_ese) begin
            ev_en <= pwdata[7:0];
         end
         if (sel_imsk) begin
            imsk <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ev_st <= psic_pkg::ESE_ST_RST;
         ist <= psic_pkg::IST_RST;
         pend_q <= 1'b0;
         pin_out <= 1'b1;
         pin_oe <= 1'b0;
         powerdown_req <= 1'b0;
         irq <= 1'b0;
      end else begin
         ev_st <= next_ev_st;
         ist <= next_ist;
         pend_q <= pending;
         pin_out <= ~pending;
         pin_oe <= ctl.pin_irq_out;
         powerdown_req <= next_pd;
         irq <= |(next_ist & imsk);
      end
   end

endmodule
`default_nettype wire

// File: verif/psic_pin_peer.sv
// psic_pin_peer: board side of the shared power-down/interrupt pin
`timescale 1ns/100ps
`default_nettype none
module psic_pin_peer (
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic pd_n,
   output logic pin_in
);
   // pulled up; either side may pull low, so contention reads low
   assign pin_in = !((pin_oe && !pin_out) || !pd_n);
endmodule
`default_nettype wire

// File: verif/psic_top_props.sv
// psic_top_props: port-level checks of the status and interrupt block
`timescale 1ns/100ps
`default_nettype none
module psic_top_props (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire psic_pkg::psic_line_t line_status,
   input wire psic_pkg::psic_evt_t events,
   input wire logic pin_in,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic powerdown_req,
   input wire logic irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire setup = psel && !penable;
   wire sum_rd = setup && !pwrite && paddr == 8'h40;
   wire bad = !(paddr inside {8'h40, 8'h44, 8'h48, 8'h4C, 8'h50});
   a_ready_next: assert property (setup |=> pready)
      else $error("no answer after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_bad_addr: assert property (setup && bad |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_read_hi: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("upper read data not zero");
   a_ctl_zero: assert property (
      pready && !pwrite && paddr == 8'h44 |-> prdata[15:4] == 12'h0)
      else $error("control reserved bits not zero");
   a_sum_live: assert property (
      sum_rd |=> prdata[4:0] == $past(line_status[4:0]))
      else $error("summary bits do not follow line status");
   a_jab_gate: assert property (
      sum_rd |=> prdata[5] == ($past(line_status[5]) && $past(line_status[1]))
      && !prdata[6])
      else $error("jabber bit wrong");
   a_pd_input: assert property (
      (!pin_oe && !pin_in) [*2] |-> powerdown_req)
      else $error("power-down input not seen");
   a_pd_masked: assert property (pin_oe [*2] |-> !powerdown_req)
      else $error("power-down while pin is output");
   cover property (setup && bad);
   cover property (pin_oe && !pin_out);
   cover property (powerdown_req);
   cover property (irq);
endmodule
bind psic_top psic_top_props chk_i (
   .sys_clk(sys_clk),
   .rst(rst),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .line_status(line_status),
   .events(events),
   .pin_in(pin_in),
   .pin_out(pin_out),
   .pin_oe(pin_oe),
   .powerdown_req(powerdown_req),
   .irq(irq)
);
`default_nettype wire

// File: verif/psic_top_tb.sv
// psic_top_tb: register-level tests of status summary and interrupt control
`timescale 1ns/100ps
`default_nettype none
module psic_top_tb;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, er, pd_n;
   logic pin_in, pin_out, pin_oe, powerdown_req, irq;
   logic [7:0] paddr;
   logic [3:0] pstrb;
   logic [31:0] pwdata, prdata, rdat;
   psic_pkg::psic_line_t line_status;
   psic_pkg::psic_evt_t events;
   int err_count, total_checks, cyc;
   psic_top uut (
      .sys_clk(sys_clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .line_status(line_status),
      .events(events),
      .pin_in(pin_in),
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .powerdown_req(powerdown_req),
      .irq(irq)
   );
   psic_pin_peer peer (
      .pin_out(pin_out),
      .pin_oe(pin_oe),
      .pd_n(pd_n),
      .pin_in(pin_in)
   );
   initial begin
      sys_clk = 0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic final_report;
      if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_count++;
         final_report;
      end
   end
   task automatic chk(input string s, input logic [31:0] e,
      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   // one idle edge after each transfer keeps drivers single per step
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         err_count++;
         $display("mismatch pready expected 1 seen %b", pready);
      end
      rdat = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rdat);
   endtask
   task automatic ev(input logic [3:0] v);
      events <= v;
      @(posedge sys_clk);
      events <= 4'h0;
      @(posedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, paddr, pwdata, events} = '0;
      pstrb = 4'hF;
      pd_n = 1;
      line_status = 6'h23;
      rst = 1;
      repeat (4) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      repeat (2) rd(8'h40, 32'h23);
      line_status <= 6'h3C;
      rd(8'h40, 32'h1C);
      rd(8'h48, 32'h3C00);
      rd(8'h48, 32'h0);
      apb(1, 8'h44, 32'hFFFFFFFF);
      rd(8'h44, 32'hF);
      rd(8'h40, 32'h9C);
      chk("pin_out", 32'h0, 32'(pin_out));
      pstrb <= 4'h0;
      apb(1, 8'h44, 32'h0);
      pstrb <= 4'hF;
      rd(8'h44, 32'hF);
      apb(1, 8'h44, 32'h9);
      rd(8'h44, 32'h9);
      chk("pin_oe", 32'h1, 32'(pin_oe));
      chk("pin_out", 32'h1, 32'(pin_out));
      // level change and time pulse land on the same edge, before the read
      line_status <= 6'h38;
      ev(4'h1);
      rd(8'h48, 32'h1800);
      apb(1, 8'h44, 32'h3);
      apb(1, 8'h48, 32'h80);
      ev(4'h8);
      rd(8'h40, 32'h98);
      chk("pin_out", 32'h0, 32'(pin_out));
      rd(8'h48, 32'h8080);
      rd(8'h40, 32'h18);
      apb(1, 8'h44, 32'h1);
      ev(4'h8);
      rd(8'h40, 32'h18);
      chk("pin_out", 32'h1, 32'(pin_out));
      rd(8'h48, 32'h8080);
      chk("irq", 32'h0, 32'(irq));
      ev(4'h6);
      rd(8'h48, 32'h4280);
      // drop stale pending edges so only the test force can raise irq
      apb(1, 8'h4C, 32'h3);
      apb(1, 8'h50, 32'h1);
      chk("irq", 32'h0, 32'(irq));
      apb(1, 8'h44, 32'h5);
      rd(8'h4C, 32'h1);
      chk("irq", 32'h1, 32'(irq));
      apb(1, 8'h44, 32'h1);
      apb(1, 8'h4C, 32'h1);
      rd(8'h4C, 32'h0);
      chk("irq", 32'h0, 32'(irq));
      rd(8'h50, 32'h1);
      apb(1, 8'h44, 32'h0);
      pd_n <= 0;
      repeat (3) @(posedge sys_clk);
      chk("powerdown_req", 32'h1, 32'(powerdown_req));
      chk("pin_oe", 32'h0, 32'(pin_oe));
      rd(8'h4C, 32'h2);
      chk("irq", 32'h0, 32'(irq));
      pd_n <= 1;
      apb(1, 8'h7C, 32'h5);
      chk("pslverr", 32'h1, 32'(er));
      rd(8'h7C, 32'h0);
      // mid-run reset: registers back to reset, no false change events
      rst <= 1;
      repeat (2) @(posedge sys_clk);
      rst <= 0;
      @(posedge sys_clk);
      rd(8'h48, 32'h0);
      rd(8'h4C, 32'h0);
      rd(8'h50, 32'h0);
      rd(8'h44, 32'h0);
      final_report;
   end
endmodule
`default_nettype wire
